//--- core_state_model.sv
// Partner model: the core's working registers and register banks.
// Assumes the bench picks bank, accumulator and pointer as plain levels.
module core_state_model (
  // Selection from the bench
  input wire logic [1:0] bank,
  input wire logic [7:0] acc,
  input wire logic [15:0] ptr,
  // Towards the addressing unit
  output opaddr_pkg::core_state_s core_state
);
  timeunit 1ns;
  timeprecision 1ns;
  import opaddr_pkg::*;
  // Contents differ per bank, so a unit reading the wrong bank shows a wrong address
  always_comb begin
    core_state = '{acc, ptr, bank, {bank, 6'h11}, {bank, 6'h2a}};
  end
endmodule : core_state_model

//--- opaddr_pkg.sv
// Constants, types and operation summary for the operand addressing unit.
// Assumes a single 20 MHz clock and an instruction decoder that presents
// one opcode plus up to two following instruction bytes per request.
// Operation
// RL1: Classic instruction set, one or two cycles
// RL2: Direct mode: 8-bit address, internal RAM/special regs
// RL3: 8-bit indirect through bank register zero or one
// RL4: 16-bit indirect through wide address pointer
// RL5: Register mode: opcode picks one of eight
// RL6: Register-specific: operand implied, e.g. accumulator
// RL7: Immediate: instruction byte is value, not address
// RL8: Indexed mode only for program memory reads
// RL9: Indexed address is pointer plus accumulator; code adds the accumulator for 0x93 only, 0x83 gives the pointer alone
// RL10: Bit mode: 8-bit address over 256 bits
// RL11: External reset pin active low, pulled up
// RL12: Configuration lets alternate pin also reset
// RL13: Bits map to 128 RAM bits plus special regs
// RL14: External RAM: accumulator only, indirect only
// RL15: Decode reports addressing mode per operand
package opaddr_pkg;

  // ****************************************
  // Modes and spaces
  // ****************************************
  typedef enum logic [2:0] {
    MODE_NONE = 3'h0,
    MODE_DIRECT = 3'h1,
    MODE_INDIRECT = 3'h2,
    MODE_REGISTER = 3'h3,
    MODE_REG_SPECIFIC = 3'h4,
    MODE_IMMEDIATE = 3'h5,
    MODE_INDEXED = 3'h6,
    MODE_BIT = 3'h7
  } addr_mode_e;

  typedef enum logic [2:0] {
    SPACE_NONE = 3'h0,
    SPACE_IRAM = 3'h1,
    SPACE_SFR = 3'h2,
    SPACE_XRAM = 3'h3,
    SPACE_CODE = 3'h4,
    SPACE_BIT = 3'h5,
    SPACE_VALUE = 3'h6
  } mem_space_e;

  // ****************************************
  // Constants
  // ****************************************
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] BIT_RAM_BYTE_BASE = 8'h20;
  localparam logic [7:0] BIT_SFR_MASK = 8'hf8;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [1:0] RESET_CYCLES = 2'h0;
  localparam logic [1:0] MULTI_CYCLES = 2'h2;
  localparam logic [1:0] SINGLE_CYCLES = 2'h1;
  localparam logic [1:0] RST_SYNC_RESET = 2'h0;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } instr_s;

  typedef struct packed {
    logic [7:0] acc;
    logic [15:0] wide_address_pointer;
    logic [1:0] bank;
    logic [7:0] bank_r0;
    logic [7:0] bank_r1;
  } core_state_s;

  typedef struct packed {
    addr_mode_e mode;
    mem_space_e space;
    logic [15:0] addr;
    logic [2:0] bit_pos;
    logic [7:0] value;
    logic [1:0] cycles;
    logic xram_write;
  } operand_s;

endpackage : opaddr_pkg

//--- operand_addressing_unit.sv
// Operand addressing unit: resolves the first operand of each instruction.
// Assumes the decoder holds instr stable with instr_valid high for one cycle
// and supplies the current accumulator, pointer, bank and R0/R1 contents.
module operand_addressing_unit (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Reset pins and configuration
  input wire logic external_reset_pin,
  input wire logic alternate_reset_pin,
  input wire logic alt_reset_enable,
  // Decoder side
  input wire logic instr_valid,
  input wire opaddr_pkg::instr_s instr,
  input wire opaddr_pkg::core_state_s core_state,
  // Memory side
  output opaddr_pkg::operand_s operand,
  output logic operand_valid,
  output logic core_reset_n
);
  import opaddr_pkg::*;

  // ****************************************
  // Functions
  // ****************************************
  // Bank register address in internal RAM
  function automatic logic [7:0] bank_reg_addr(input logic [1:0] bank, input logic [2:0] idx);
    bank_reg_addr = {3'h0, bank, idx};
  endfunction : bank_reg_addr

  // Direct address goes to special regs at and above the base
  function automatic mem_space_e direct_space(input logic [7:0] a);
    direct_space = (a >= SFR_BASE) ? SPACE_SFR : SPACE_IRAM;
  endfunction : direct_space

  // ****************************************
  // Reset pins
  // ****************************************
  // Pins arrive synchronous; pull-up is external to this logic, so open reads high
  logic pin_reset;
  logic [1:0] rst_hold;
  logic [1:0] next_rst_hold;
  logic next_core_reset_n;

  always_comb begin
    pin_reset = !external_reset_pin; // RL11
    if (alt_reset_enable && !alternate_reset_pin) begin
      pin_reset = 1'b1; // RL12
    end
    // An external pin pulse, or an alternate pin pulse with alt_reset_enable set, restarts the count, so even a one-cycle pulse gives a full reset
    next_rst_hold = pin_reset ? RST_SYNC_RESET : {rst_hold[0], 1'b1};
    next_core_reset_n = rst_hold[1] && !pin_reset;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_hold <= RST_SYNC_RESET;
      core_reset_n <= 1'b0;
    end else begin
      rst_hold <= next_rst_hold;
      core_reset_n <= next_core_reset_n;
    end
  end

  // ****************************************
  // Operand decode
  // ****************************************
  operand_s next_operand;
  logic next_operand_valid;
  logic [7:0] op;
  logic [7:0] bit_byte;

  always_comb begin
    op = instr.opcode;
    bit_byte = RESET_BYTE;
    next_operand = '0;
    next_operand.cycles = SINGLE_CYCLES; // RL1
    next_operand_valid = instr_valid;
    if (op[3:0] >= 4'h8 && op[7:4] != 4'h0 && op[7:4] != 4'h1 && op[7:4] != 4'hd) begin
      next_operand.mode = MODE_REGISTER; // RL5
      next_operand.space = SPACE_IRAM;
      next_operand.addr = {8'h00, bank_reg_addr(core_state.bank, op[2:0])}; // RL5
    end else if (op == 8'he0 || op == 8'hf0 || op == 8'he2 || op == 8'he3 || op == 8'hf2
                 || op == 8'hf3) begin
      next_operand.mode = MODE_INDIRECT; // RL14
      next_operand.space = SPACE_XRAM;
      next_operand.xram_write = op[4]; // RL14
      next_operand.cycles = MULTI_CYCLES;
      if (op[1]) begin
        next_operand.addr = {8'h00, op[0] ? core_state.bank_r1 : core_state.bank_r0}; // RL3
      end else begin
        next_operand.addr = core_state.wide_address_pointer; // RL4
      end
    end else if (op == 8'h93 || op == 8'h83) begin
      next_operand.mode = MODE_INDEXED; // RL8
      next_operand.space = SPACE_CODE;
      next_operand.cycles = MULTI_CYCLES;
      next_operand.addr = op[4] ? core_state.wide_address_pointer + {8'h00, core_state.acc}
                                : core_state.wide_address_pointer; // RL9
    end else if (op[3:1] == 3'h3 && op[7:4] != 4'h0 && op[7:4] != 4'h1 && op[7:4] != 4'hd) begin
      next_operand.mode = MODE_INDIRECT;
      next_operand.space = SPACE_IRAM;
      next_operand.cycles = MULTI_CYCLES;
      next_operand.addr = {8'h00, op[0] ? core_state.bank_r1 : core_state.bank_r0}; // RL3
    end else if (op == 8'h92 || op == 8'ha2 || op == 8'hb2 || op == 8'hc2 || op == 8'hd2
                 || op == 8'h72 || op == 8'h82 || op == 8'ha0 || op == 8'hb0) begin
      next_operand.mode = MODE_BIT; // RL10
      next_operand.space = SPACE_BIT;
      next_operand.cycles = MULTI_CYCLES;
      next_operand.bit_pos = instr.byte1[2:0];
      if (instr.byte1[7]) begin
        bit_byte = instr.byte1 & BIT_SFR_MASK; // RL13
      end else begin
        bit_byte = BIT_RAM_BYTE_BASE + {4'h0, instr.byte1[6:3]}; // RL13
      end
      next_operand.addr = {8'h00, bit_byte};
    end else if (op[3:0] == 4'h4 && op[7:4] >= 4'h2 && op[7:4] != 4'h8 && op[7:4] <= 4'h9) begin
      next_operand.mode = MODE_IMMEDIATE; // RL7
      next_operand.space = SPACE_VALUE;
      next_operand.cycles = MULTI_CYCLES;
      next_operand.value = instr.byte1; // RL7
    end else if (op[3:0] == 4'h5 && op[7:4] >= 4'h2) begin
      next_operand.mode = MODE_DIRECT; // RL2
      next_operand.space = direct_space(instr.byte1); // RL2
      next_operand.cycles = MULTI_CYCLES;
      next_operand.addr = {8'h00, instr.byte1};
    end else if (op[3:0] == 4'h4 || op == 8'ha3) begin
      next_operand.mode = MODE_REG_SPECIFIC; // RL6
      next_operand.space = SPACE_NONE;
      next_operand.value = core_state.acc;
    end else begin
      next_operand.mode = MODE_NONE; // RL15
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      operand <= '0;
      operand_valid <= 1'b0;
    end else begin
      operand <= next_operand; // RL15
      operand_valid <= next_operand_valid;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  // Operand checks after |=> compare against the decoder's inputs one cycle back; the |-> ones check the operand alone
  a_valid_follows: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL15
    instr_valid |=> operand_valid) else $error("valid lost");
  a_valid_idle: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL15
    !instr_valid |=> !operand_valid) else $error("valid without request");
  a_direct_space: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL2
    instr_valid && instr.opcode == 8'he5 |=> operand.addr == {8'h00, $past(instr.byte1)}
    && operand.space == ($past(instr.byte1) >= SFR_BASE ? SPACE_SFR : SPACE_IRAM))
    else $error("direct space");
  a_indirect_reg: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL3
    instr_valid && instr.opcode == 8'he7 |=> operand.mode == MODE_INDIRECT
    && operand.addr == {8'h00, $past(core_state.bank_r1)}) else $error("indirect register");
  a_wide_ptr: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL4
    instr_valid && instr.opcode == 8'he0 |=> operand.space == SPACE_XRAM
    && operand.addr == $past(core_state.wide_address_pointer)) else $error("wide pointer");
  a_register_addr: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL5
    instr_valid && instr.opcode[7:3] == 5'h1d |=>
    operand.addr[7:0] == {3'h0, $past(core_state.bank), $past(instr.opcode[2:0])})
    else $error("register addr");
  a_regspec_acc: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL6
    instr_valid && instr.opcode == 8'h04 |=> operand.mode == MODE_REG_SPECIFIC
    && operand.value == $past(core_state.acc)) else $error("accumulator operand");
  a_div_regspec: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL6
    instr_valid && instr.opcode == 8'h84 |=> operand.mode == MODE_REG_SPECIFIC)
    else $error("divide operand");
  a_imm_value: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL7
    instr_valid && instr.opcode == 8'h74 |=> operand.value == $past(instr.byte1)
    && operand.space == SPACE_VALUE) else $error("immediate");
  a_indexed_code: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL8
    instr_valid && (instr.opcode == 8'h93 || instr.opcode == 8'h83) |=>
    operand.mode == MODE_INDEXED && operand.space == SPACE_CODE) else $error("indexed space");
  a_indexed_sum: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL9
    instr_valid && instr.opcode == 8'h93 |=>
    operand.addr == $past(core_state.wide_address_pointer) + {8'h00, $past(core_state.acc)})
    else $error("indexed sum");
  a_bit_ram: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL10
    instr_valid && instr.opcode == 8'hd2 && !instr.byte1[7] |=>
    operand.addr[3:0] == $past(instr.byte1[6:3]) && operand.bit_pos == $past(instr.byte1[2:0]))
    else $error("bit position");
  a_bit_range: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL13
    operand_valid && operand.mode == MODE_BIT && !operand.addr[7] |->
    operand.addr[7:0] >= 8'h20 && operand.addr[7:0] <= 8'h2f) else $error("bit ram");
  a_bit_sfr: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL13
    instr_valid && instr.opcode == 8'hd2 && instr.byte1[7] |=>
    operand.addr == {8'h00, $past(instr.byte1) & BIT_SFR_MASK}) else $error("bit special");
  a_xram_indirect: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL14
    operand_valid && operand.space == SPACE_XRAM |-> operand.mode == MODE_INDIRECT)
    else $error("xram mode");
  a_xram_write: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL14
    instr_valid && instr.opcode == 8'hf0 |=> operand.xram_write) else $error("xram write");
  a_cycles_range: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL1
    operand_valid |-> operand.cycles == 2'h1 || operand.cycles == 2'h2)
    else $error("cycles");
  a_register_cycles: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL1
    instr_valid && instr.opcode[7:3] == 5'h1d |=> operand.cycles == SINGLE_CYCLES)
    else $error("register cycles");

  // Reset output checks; the system reset itself is left to disable iff
  a_pin_reset: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL11
    !external_reset_pin |=> !core_reset_n) else $error("pin reset");
  a_reset_stretch: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL11
    $rose(external_reset_pin) |=> !core_reset_n) else $error("reset too short");
  a_alt_reset: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL12
    alt_reset_enable && !alternate_reset_pin |=> !core_reset_n) else $error("alt reset");
  a_release: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL11
    (external_reset_pin && !(alt_reset_enable && !alternate_reset_pin)) [*3] |=> core_reset_n)
    else $error("release");

  c_indexed: cover property (@(posedge sys_clk) operand_valid && operand.mode == MODE_INDEXED);
  c_xram_write: cover property (@(posedge sys_clk) operand_valid && operand.xram_write);
  c_bit_sfr: cover property (@(posedge sys_clk) operand_valid && operand.mode == MODE_BIT
    && operand.addr[7]);
  c_alt_reset: cover property (@(posedge sys_clk) alt_reset_enable && !alternate_reset_pin);
  c_mode_none: cover property (@(posedge sys_clk) operand_valid && operand.mode == MODE_NONE);

endmodule : operand_addressing_unit

//--- operand_addressing_unit_bench.sv
// Testbench for the operand addressing unit: instruction table, then reset cases.
// Assumes the core state model supplies the accumulator, pointer and banks.
module operand_addressing_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import opaddr_pkg::*;
  // ****************************************
  // Signals and table
  // ****************************************
  typedef struct packed {
    instr_s i;
    addr_mode_e m;
    mem_space_e s;
    logic [15:0] a;
    logic [7:0] v;
  } row_s;
  logic sys_clk = 0, reset_n = 0, external_reset_pin = 1, alternate_reset_pin = 1;
  logic alt_reset_enable = 0, instr_valid = 0, operand_valid, core_reset_n;
  logic [1:0] bank = 2'h2;
  logic [7:0] acc = 8'h34;
  logic [15:0] ptr = 16'h12f0;
  instr_s instr = '0;
  core_state_s core_state;
  operand_s operand;
  int miscompares = 0, cmp_count = 0;
  row_s rows [15] = '{
    '{'{8'he5, 8'h45, 8'h00}, MODE_DIRECT, SPACE_IRAM, 16'h0045, 8'h00},
    '{'{8'he5, 8'h90, 8'h00}, MODE_DIRECT, SPACE_SFR, 16'h0090, 8'h00},
    '{'{8'he6, 8'h00, 8'h00}, MODE_INDIRECT, SPACE_IRAM, 16'h0091, 8'h00},
    '{'{8'he7, 8'h00, 8'h00}, MODE_INDIRECT, SPACE_IRAM, 16'h00aa, 8'h00},
    '{'{8'he0, 8'h00, 8'h00}, MODE_INDIRECT, SPACE_XRAM, 16'h12f0, 8'h00},
    '{'{8'he2, 8'h00, 8'h00}, MODE_INDIRECT, SPACE_XRAM, 16'h0091, 8'h00},
    '{'{8'hed, 8'h00, 8'h00}, MODE_REGISTER, SPACE_IRAM, 16'h0015, 8'h00},
    '{'{8'h04, 8'h00, 8'h00}, MODE_REG_SPECIFIC, SPACE_NONE, 16'h0000, 8'h34},
    '{'{8'h74, 8'h5c, 8'h00}, MODE_IMMEDIATE, SPACE_VALUE, 16'h0000, 8'h5c},
    '{'{8'h93, 8'h00, 8'h00}, MODE_INDEXED, SPACE_CODE, 16'h1324, 8'h00},
    '{'{8'hd2, 8'h0b, 8'h00}, MODE_BIT, SPACE_BIT, 16'h0021, 8'h00},
    '{'{8'hd2, 8'h93, 8'h00}, MODE_BIT, SPACE_BIT, 16'h0090, 8'h00},
    '{'{8'hf3, 8'h00, 8'h00}, MODE_INDIRECT, SPACE_XRAM, 16'h00aa, 8'h00},
    '{'{8'h84, 8'h00, 8'h00}, MODE_REG_SPECIFIC, SPACE_NONE, 16'h0000, 8'h34},
    '{'{8'h00, 8'h00, 8'h00}, MODE_NONE, SPACE_NONE, 16'h0000, 8'h00}};

  operand_addressing_unit dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .external_reset_pin(external_reset_pin), .alternate_reset_pin(alternate_reset_pin),
    .alt_reset_enable(alt_reset_enable), .instr_valid(instr_valid), .instr(instr),
    .core_state(core_state), .operand(operand), .operand_valid(operand_valid),
    .core_reset_n(core_reset_n));
  core_state_model partner (.bank(bank), .acc(acc), .ptr(ptr), .core_state(core_state));

  // ****************************************
  // Helpers
  // ****************************************
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Compares the answer to one row; fields a mode leaves open are skipped
  task automatic check_row(input row_s r);
    check("operand_valid", operand_valid, 1'b1);
    check("mode", operand.mode, r.m);
    if (r.m inside {MODE_IMMEDIATE, MODE_REG_SPECIFIC}) begin
      check("value", operand.value, r.v);
    end else if (r.m != MODE_NONE) begin
      check("space", operand.space, r.s);
      check("addr", operand.addr, r.a);
    end
    if (r.m inside {MODE_REGISTER, MODE_REG_SPECIFIC}) begin
      check("cycles", operand.cycles, SINGLE_CYCLES);
    end else if (r.m != MODE_NONE) begin
      check("cycles", operand.cycles, MULTI_CYCLES);
    end
    if (r.m == MODE_BIT) begin
      check("bit_pos", operand.bit_pos, r.i.byte1[2:0]);
    end
    if (r.s == SPACE_XRAM) begin
      check("xram_write", operand.xram_write, r.i.opcode inside {8'hf0, 8'hf2, 8'hf3});
    end
  endtask : check_row

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #(1000 * 50);
    miscompares++;
    wrap_up();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20) @(negedge sys_clk);
    check("core_reset_n", core_reset_n, 1'b0);
    check("operand_valid", operand_valid, 1'b0);
    reset_n = 1;
    repeat (2) @(negedge sys_clk);
    check("core_reset_n", core_reset_n, 1'b0);
    @(negedge sys_clk);
    check("core_reset_n", core_reset_n, 1'b1);
    $display("test reset release done");
    foreach (rows[k]) begin
      instr_valid = 1;
      instr = rows[k].i;
      @(negedge sys_clk);
      check_row(rows[k]);
      instr_valid = 0;
      @(negedge sys_clk);
    end
    check("operand_valid", operand_valid, 1'b0);
    $display("test table done");
    // Back to back: a one-cycle register read then a two-cycle direct read
    instr_valid = 1;
    instr = rows[6].i;
    @(negedge sys_clk);
    instr = rows[0].i;
    check_row(rows[6]);
    check("cycles", operand.cycles, SINGLE_CYCLES);
    @(negedge sys_clk);
    instr_valid = 0;
    check_row(rows[0]);
    check("cycles", operand.cycles, MULTI_CYCLES);
    $display("test back to back done");
    // Pin resets: alternate pin ignored until configured
    external_reset_pin = 0;
    @(negedge sys_clk);
    check("core_reset_n", core_reset_n, 1'b0);
    external_reset_pin = 1;
    @(negedge sys_clk);
    check("core_reset_n", core_reset_n, 1'b0);
    repeat (2) @(negedge sys_clk);
    check("core_reset_n", core_reset_n, 1'b1);
    alternate_reset_pin = 0;
    repeat (2) @(negedge sys_clk);
    check("core_reset_n", core_reset_n, 1'b1);
    alt_reset_enable = 1;
    @(negedge sys_clk);
    check("core_reset_n", core_reset_n, 1'b0);
    alternate_reset_pin = 1;
    repeat (3) @(negedge sys_clk);
    check("core_reset_n", core_reset_n, 1'b1);
    $display("test reset pins done");
    // Mid-run system reset drops a pending answer and restarts the release count
    instr_valid = 1;
    instr = rows[9].i;
    @(negedge sys_clk);
    instr_valid = 0;
    reset_n = 0;
    @(negedge sys_clk);
    check("operand_valid", operand_valid, 1'b0);
    check("mode", operand.mode, MODE_NONE);
    check("core_reset_n", core_reset_n, 1'b0);
    reset_n = 1;
    repeat (2) @(negedge sys_clk);
    check("core_reset_n", core_reset_n, 1'b0);
    @(negedge sys_clk);
    check("core_reset_n", core_reset_n, 1'b1);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule : operand_addressing_unit_bench
